// >>> regulator_pkg.sv
// package: register map, field positions and reset values of the regulator control block
package regulator_pkg;
   localparam logic [7:0] REGULATOR_CONTROL_OFFSET = 8'h00;
   localparam int         IRQ_FLAG_BIT             = 0;
   localparam int         IRQ_ENABLE_BIT           = 1;
   localparam int         STATUS_BIT               = 2;
   localparam logic       IRQ_ENABLE_RESET         = 1'b0;
   localparam logic       IRQ_FLAG_RESET           = 1'b0;
   localparam logic [4:0] RESERVED_READ            = 5'h00;
   localparam logic [31:0] UNMAPPED_READ           = 32'h00000000;
   typedef enum logic [1:0] {
      MODE_FULL,
      MODE_REDUCED,
      MODE_SHUTDOWN
   } reg_mode_t;
endpackage

// >>> level_sync.sv
// two-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module level_sync
   import regulator_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic rst_val_i,
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_q;
   logic sync_q;

   // ---------------------------------------------------------------
   // synchroniser stages
   // ---------------------------------------------------------------
   // reset value comes in as a tie-off constant from the parent
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= rst_val_i;
         sync_q <= rst_val_i;
      end else if (ce_i) begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule

// >>> regulator_ctrl.sv
// regulator mode control, undervoltage status and interrupt, power-on reset pass-through
// Function
// - status bit 2 is read-only, mirrors comparator; writes ignored.
// - detector updates status only in full performance; otherwise status reads 0.
// - interrupt flag bit 0 sets on any status change.
// - flag clears only by writing 1; writing 0 leaves it.
// - with enable bit 1 set, flag drives interrupt request; else none.
// - entering reduced power does not clear the flag.
// - enable pin low selects shutdown; high selects full or reduced power.
// - power-on reset output high while supply low, low once above.
// - power-on reset works in every mode.
// - reduced power in stop mode, full performance otherwise, unless shutdown.
`timescale 1ns/100ps
module regulator_ctrl
   import regulator_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        regulator_enable_pin_i,
   input  wire logic        stop_mode_i,
   input  wire logic        undervoltage_cmp_i,
   input  wire logic        supply_low_i,
   output logic             power_on_reset_o,
   output logic             undervoltage_irq_o,
   output logic [1:0]       mode_o
);
   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic cmp_s;
   logic por_s;
   logic en_s;
   logic stop_q;

   level_sync u_sync_cmp (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .rst_val_i (1'b0),
      .async_i   (undervoltage_cmp_i),
      .sync_o    (cmp_s)
   );

   // power-on reset held high through reset so the core never sees a glitch low
   level_sync u_sync_por (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .rst_val_i (1'b1),
      .async_i   (supply_low_i),
      .sync_o    (por_s)
   );

   level_sync u_sync_en (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .rst_val_i (1'b1),
      .async_i   (regulator_enable_pin_i),
      .sync_o    (en_s)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_q <= 1'b0;
      end else if (ce_i) begin
         stop_q <= stop_mode_i;
      end
   end

   // ---------------------------------------------------------------
   // operating mode
   // ---------------------------------------------------------------
   reg_mode_t mode_q;
   reg_mode_t mode_d;

   // pin is assumed static while powered, so no hysteresis is built
   always_comb begin
      if (!en_s) begin
         mode_d = MODE_SHUTDOWN;
      end else if (stop_q) begin
         mode_d = MODE_REDUCED;
      end else begin
         mode_d = MODE_FULL;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= MODE_FULL;
      end else if (ce_i) begin
         mode_q <= mode_d;
      end
   end

   assign mode_o = mode_q;

   // ---------------------------------------------------------------
   // undervoltage status
   // ---------------------------------------------------------------
   logic status_q;
   logic status_d;

   always_comb begin
      case (mode_q)
         MODE_FULL:     status_d = cmp_s;
         MODE_REDUCED:  status_d = 1'b0;
         MODE_SHUTDOWN: status_d = 1'b0;
         default:       status_d = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_q <= 1'b0;
      end else if (ce_i) begin
         status_q <= status_d;
      end
   end

   // ---------------------------------------------------------------
   // wishbone slave
   // ---------------------------------------------------------------
   logic req;
   logic hit;
   logic wr_lane0;
   logic ack_q;
   logic [31:0] rdata_q;

   assign req      = wb_cyc_i && wb_stb_i && !ack_q;
   assign hit      = (wb_adr_i == REGULATOR_CONTROL_OFFSET);
   assign wr_lane0 = req && ce_i && wb_we_i && hit && wb_sel_i[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else if (ce_i) begin
         ack_q <= req;
      end
   end

   assign wb_ack_o = ack_q;

   // ---------------------------------------------------------------
   // control fields and interrupt
   // ---------------------------------------------------------------
   logic irq_en_q;
   logic irq_flag_q;
   logic status_change;

   assign status_change = (status_d != status_q);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_en_q <= IRQ_ENABLE_RESET;
      end else if (wr_lane0) begin
         irq_en_q <= wb_dat_i[IRQ_ENABLE_BIT];
      end
   end

   // set beats a same-cycle clear; mode changes never clear the flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_flag_q <= IRQ_FLAG_RESET;
      end else if (ce_i) begin
         if (status_change) begin
            irq_flag_q <= 1'b1;
         end else if (wr_lane0 && wb_dat_i[IRQ_FLAG_BIT]) begin
            irq_flag_q <= 1'b0;
         end
      end
   end

   assign undervoltage_irq_o = irq_en_q && irq_flag_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= UNMAPPED_READ;
      end else if (ce_i && req) begin
         if (hit) begin
            rdata_q <= {24'h000000, RESERVED_READ, status_q, irq_en_q, irq_flag_q};
         end else begin
            rdata_q <= UNMAPPED_READ;
         end
      end
   end

   assign wb_dat_o = rdata_q;

   // ---------------------------------------------------------------
   // power-on reset
   // ---------------------------------------------------------------
   // not gated by mode: it must hold in reduced power and shutdown too
   assign power_on_reset_o = por_s;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_STATUS_ZERO_OFF_FULL: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && mode_q != MODE_FULL) |=> (!status_q || !ce_i))
      else $error("status set outside full mode");

   AST_FLAG_ON_CHANGE: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && $changed(status_q)) |-> irq_flag_q)
      else $error("flag not set on status change");

   AST_FLAG_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      (irq_flag_q && !(wr_lane0 && wb_dat_i[IRQ_FLAG_BIT])) |=> irq_flag_q)
      else $error("flag cleared without write one");

   AST_FLAG_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_lane0 && wb_dat_i[IRQ_FLAG_BIT] && !status_change) |=> !irq_flag_q)
      else $error("write one did not clear flag");

   AST_IRQ_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_lane0 && !wb_dat_i[IRQ_ENABLE_BIT]) |=> !undervoltage_irq_o)
      else $error("irq not silenced by enable clear");

   AST_FLAG_SURVIVES_REDUCED: assert property (@(posedge clk_i) disable iff (rst_i)
      (irq_flag_q && mode_d == MODE_REDUCED && mode_q == MODE_FULL && !wr_lane0) |=> irq_flag_q)
      else $error("flag lost on reduced entry");

   AST_SHUTDOWN_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !en_s) |=> (mode_q == MODE_SHUTDOWN || !ce_i))
      else $error("shutdown not selected with pin low");

   AST_POR_FOLLOW: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && supply_low_i) ##1 ce_i [*2] |-> power_on_reset_o)
      else $error("reset output low with supply low");

   AST_REDUCED_IN_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && en_s && stop_q) |=> (mode_q == MODE_REDUCED || !ce_i))
      else $error("not reduced in stop");

   AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_dat_o[7:3] == 5'h00)
      else $error("reserved bits nonzero");

   AST_STATUS_TRACKS: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && mode_q == MODE_FULL) |=> (status_q == $past(cmp_s)))
      else $error("status not following comparator");

   AST_STATUS_READ_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_lane0 && !status_change) |=> $stable(status_q))
      else $error("status moved by a write");

   AST_FLAG_ONLY_ON_CHANGE: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(irq_flag_q) |-> $past(status_change))
      else $error("flag set without status change");

   AST_ENABLE_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_lane0 |=> (irq_en_q == $past(wb_dat_i[IRQ_ENABLE_BIT])))
      else $error("enable bit not written");

   AST_POR_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !supply_low_i) ##1 ce_i [*2] |-> !power_on_reset_o)
      else $error("reset output high with supply good");

   AST_POR_ANY_MODE: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && mode_q != MODE_FULL && supply_low_i) ##1 ce_i [*2] |-> power_on_reset_o)
      else $error("reset output lost outside full mode");

   AST_CMP_SYNC: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && undervoltage_cmp_i) ##1 ce_i [*2] |-> cmp_s)
      else $error("comparator not through two stages");

   // ---------------------------------------------------------------
   // register bus checks
   // ---------------------------------------------------------------
   // ack freezes with ce low, so pulse checks only look at enabled edges
   AST_ACK_AFTER_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not acknowledged");

   AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && wb_ack_o) |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   AST_ACK_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !(wb_cyc_i && wb_stb_i)) |=> !wb_ack_o)
      else $error("ack without request");

   AST_READ_STATUS: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && req && hit) |=> (wb_dat_o[STATUS_BIT] == $past(status_q)))
      else $error("read status differs from status");

   AST_READ_CTRL: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && req && hit) |=> (wb_dat_o[IRQ_ENABLE_BIT] == $past(irq_en_q)
                                && wb_dat_o[IRQ_FLAG_BIT] == $past(irq_flag_q)))
      else $error("read enable or flag differs");

   AST_UNMAPPED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && req && !hit) |=> (wb_dat_o == UNMAPPED_READ))
      else $error("unmapped read not zero");
endmodule

// >>> analog_side_model.sv
// behavioural far side: comparator, supply monitor and enable pin
`timescale 1ns/100ps
module analog_side_model (
   input  wire logic clk_i,
   input  wire logic cmp_req_i,
   input  wire logic low_req_i,
   input  wire logic pin_req_i,
   output logic      cmp_o,
   output logic      low_o,
   output logic      pin_o
);
   initial begin
      cmp_o = 1'b0;
      low_o = 1'b1;
      pin_o = 1'b0;
   end
   always @(posedge clk_i) begin
      cmp_o <= cmp_req_i;
      low_o <= low_req_i;
      // pin only moves while the core is unpowered
      if (low_o) begin
         pin_o <= pin_req_i;
      end
   end
endmodule

// >>> test_regulator_ctrl.sv
// self-checking bench for the regulator control block
`timescale 1ns/100ps
module test_regulator_ctrl;
   import regulator_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, stop, cmp_r, low_r, pin_r, cmp, low, pin, por, irq, ack, ce;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, r, rnd;
   logic [1:0]  mode;
   logic        m_st, m_fl, m_en;
   int          err_count, check_count, cycles, seed;
   // ----------------------------------------
   // instances
   // ----------------------------------------
   regulator_ctrl u_regulator_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .regulator_enable_pin_i(pin), .stop_mode_i(stop), .undervoltage_cmp_i(cmp), .supply_low_i(low),
      .power_on_reset_o(por), .undervoltage_irq_o(irq), .mode_o(mode));
   analog_side_model u_analog_side_model (.clk_i(clk_i), .cmp_req_i(cmp_r), .low_req_i(low_r),
      .pin_req_i(pin_r), .cmp_o(cmp), .low_o(low), .pin_o(pin));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [31:0] exp_reg(input logic fl, input logic en, input logic st);
      return {29'h0, st, en, fl};
   endfunction
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // single classic cycle; waits for ack, takes data at that edge
   // no local limit: only the bench timeout ends a wait
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   // new comparator level; model the flag on a status change
   task automatic settle(input logic st);
      cmp_r <= st;
      if (st != m_st) m_fl = 1'b1;
      m_st = st;
      repeat (6) @(posedge clk_i);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles >= 20000) begin
         err_count++;
         conclude();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {cyc, stb, we, stop, cmp_r, pin_r, adr, wdat, err_count, check_count, cycles} = '0;
      {rst_i, low_r, sel, ce} = {1'b1, 1'b1, 4'hF, 1'b1};
      {m_st, m_fl, m_en} = 3'b000;
      seed = 32'hfbd6;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk("por_low_supply", por, 1);
      chk("mode_pin_low", mode, MODE_SHUTDOWN);
      wb(0, REGULATOR_CONTROL_OFFSET, 0, r);
      chk("reg_reset", r, exp_reg(IRQ_FLAG_RESET, IRQ_ENABLE_RESET, 0));
      pin_r <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk("mode_pin_high", mode, MODE_FULL);
      low_r <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk("por_released", por, 0);
      wb(1, REGULATOR_CONTROL_OFFSET, 32'hFFFFFFFF, r);
      m_en = 1'b1;
      wb(0, REGULATOR_CONTROL_OFFSET, 0, r);
      chk("reg_ro_bits", r, exp_reg(0, 1, 0));
      for (int i = 0; i < 24; i++) begin
         settle($random(seed) & 1);
         wb(0, REGULATOR_CONTROL_OFFSET, 0, r);
         chk("reg_status", r, exp_reg(m_fl, m_en, m_st));
         chk("irq_level", irq, m_fl & m_en);
         rnd = $random(seed);
         // lane 0 off must leave the register alone
         sel <= rnd[11:8];
         wb(1, REGULATOR_CONTROL_OFFSET, rnd, r);
         if (rnd[8]) begin
            m_en = rnd[1];
            if (rnd[0]) m_fl = 1'b0;
         end
         wb(0, REGULATOR_CONTROL_OFFSET, 0, r);
         chk("reg_after_write", r, exp_reg(m_fl, m_en, m_st));
      end
      sel <= 4'hF;
      settle(1'b1);
      wb(1, REGULATOR_CONTROL_OFFSET, 32'h3, r);
      stop <= 1'b1;
      low_r <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk("mode_stop", mode, MODE_REDUCED);
      chk("por_in_stop", por, 1);
      wb(0, REGULATOR_CONTROL_OFFSET, 0, r);
      chk("reg_in_stop", r, exp_reg(1, 1, 0));
      chk("irq_in_stop", irq, 1);
      stop <= 1'b0;
      low_r <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk("mode_run", mode, MODE_FULL);
      // clock enable low: stop request must not reach the mode
      ce <= 1'b0;
      stop <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk("mode_frozen", mode, MODE_FULL);
      ce <= 1'b1;
      stop <= 1'b0;
      repeat (6) @(posedge clk_i);
      wb(1, 8'h04, 32'hFFFFFFFF, r);
      wb(0, 8'h04, 0, r);
      chk("unmapped", r, UNMAPPED_READ);
      wb(0, REGULATOR_CONTROL_OFFSET, 0, r);
      chk("reg_unchanged", r, exp_reg(1, 1, 1));
      conclude();
   end
endmodule
